// ===== pcc_consts.svh
// Purpose: Command codes, field positions and timing counts for the channel power commands
// Assumes: 25 MHz device clock
// Notes:   Definitions only
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

`define PCC_CMD_DCEN      8'h14
`define PCC_CMD_RESTART   8'h18
`define PCC_CMD_PWR       8'h19
`define PCC_READ_ZERO     8'h00
`define PCC_POLICE_PRESET 8'hFF

// Upper nibble: classification / power-off, lower nibble: detection / power-on
`define PCC_HI_MSB        7
`define PCC_HI_LSB        4
`define PCC_LO_MSB        3
`define PCC_LO_LSB        0

`define PCC_CLK_KHZ       25000
`define PCC_CLR_TIME_US   5000
// Longest time: rounds down
`define PCC_CLR_CYC       ((`PCC_CLR_TIME_US * `PCC_CLK_KHZ) / 1000)

`endif

// ===== pcc_pkg.sv
// Purpose: Shared types of the channel power command block
// Assumes: Nothing
// Notes:   Mode codes as seen on the op_mode input
package pcc_pkg;

   typedef enum logic [1:0]
   {
      PCC_MODE_OFF    = 2'h0,
      PCC_MODE_MANUAL = 2'h1,
      PCC_MODE_SEMI   = 2'h2,
      PCC_MODE_AUTO   = 2'h3
   } pcc_mode_t;

   typedef enum logic [2:0]
   {
      PCC_ST_IDLE  = 3'b001,
      PCC_ST_ARMED = 3'b010,
      PCC_ST_ON    = 3'b100
   } pcc_state_t;

endpackage : pcc_pkg

// ===== pcc_ch_if.sv
// Purpose: Carries per-channel commands and engine status to the channel bank
// Assumes: One bit per channel in every vector except the shared mode
// Notes:   ctl is the register side, bank the sequencer side
`timescale 1ns/100ps
`default_nettype none

interface pcc_ch_if #(parameter int N = 4);
   pcc_pkg::pcc_mode_t mode;
   logic [N-1:0]       on_req;
   logic [N-1:0]       off_req;
   logic [N-1:0]       cool;
   logic [N-1:0]       disc;
   logic [N-1:0]       cls_busy;
   logic [N-1:0]       cls_done;
   logic [N-1:0]       cls_valid;
   logic [N-1:0]       alloc_ok;
   logic [N-1:0]       det_en;
   logic [N-1:0]       cls_en;
   logic [N-1:0]       pwr;
   logic [N-1:0]       cyc_req;

   modport ctl  (output mode, on_req, off_req, cool, disc, cls_busy, cls_done, cls_valid,
                 alloc_ok, det_en, cls_en, input pwr, cyc_req);
   modport bank (input mode, on_req, off_req, cool, disc, cls_busy, cls_done, cls_valid,
                 alloc_ok, det_en, cls_en, output pwr, cyc_req);
endinterface : pcc_ch_if

`default_nettype wire

// ===== pcc_chan_bank.sv
// Purpose: Per-channel turn-on sequencer for each operating mode
// Assumes: Engine pulses cls_done once per finished classification
// Notes:   One sequencer per channel, built by a generate loop
`timescale 1ns/100ps
`default_nettype none

module pcc_chan_bank
   import pcc_pkg::*;
#(
   parameter int N = 4
)
(
   input  wire logic clk,
   input  wire logic resetn,
   pcc_ch_if.bank    bus
);

   for (genvar i = 0; i < N; i++)
   begin : g_ch
      pcc_state_t state_ff;
      pcc_state_t nxt_state;
      logic       skip_ff;
      logic       nxt_skip;
      logic       cyc;
      wire        both    = bus.det_en[i] & bus.cls_en[i];
      wire        on_ok   = bus.on_req[i] & ~bus.off_req[i] & ~bus.cool[i]
                            & (bus.mode != PCC_MODE_OFF);
      wire        done_ok = bus.cls_done[i] & bus.cls_valid[i] & bus.alloc_ok[i]
                            & ~bus.cool[i];

      always_comb
      begin
         nxt_state = state_ff;
         nxt_skip  = skip_ff;
         cyc       = 1'b0;
         if (bus.off_req[i] || bus.disc[i] || bus.cool[i])
         begin
            // Off, disconnect and cool-down outrank any turn-on
            nxt_state = PCC_ST_IDLE;
            nxt_skip  = 1'b0;
         end
         else if (on_ok && bus.mode == PCC_MODE_MANUAL)
            nxt_state = PCC_ST_ON;
         else
         begin
            case (state_ff)
               PCC_ST_IDLE:
               begin
                  if (on_ok && state_ff == PCC_ST_IDLE)
                  begin
                     nxt_state = PCC_ST_ARMED;
                     if (both && bus.mode == PCC_MODE_SEMI)
                        // A class already running is too late for this request
                        nxt_skip = bus.cls_busy[i];
                     else
                        cyc = 1'b1;
                  end
                  else if (bus.mode == PCC_MODE_AUTO && both && done_ok)
                     nxt_state = PCC_ST_ON;
               end
               PCC_ST_ARMED:
               begin
                  if (bus.cls_done[i] && skip_ff)
                     nxt_skip = 1'b0;
                  else if (bus.cls_done[i])
                     // Single attempt: failure drops back with no retry
                     nxt_state = done_ok ? PCC_ST_ON : PCC_ST_IDLE;
               end
               PCC_ST_ON:
                  nxt_state = PCC_ST_ON;
               default:
                  nxt_state = PCC_ST_IDLE;
            endcase
         end
      end

      always_ff @(posedge clk or negedge resetn)
      begin
         if (!resetn)
         begin
            state_ff <= PCC_ST_IDLE;
            skip_ff  <= 1'b0;
         end
         else
         begin
            state_ff <= nxt_state;
            skip_ff  <= nxt_skip;
         end
      end

      assign bus.pwr[i]     = (state_ff == PCC_ST_ON);
      assign bus.cyc_req[i] = cyc;
   end

endmodule : pcc_chan_bank

`default_nettype wire

// ===== pcc_off_clear.sv
// Purpose: Field-clear strobes and busy window after a power-off
// Assumes: Downstream field owners act on the one-cycle strobe
// Notes:   Busy window restarts on every new power-off
`timescale 1ns/100ps
`default_nettype none

`include "pcc_consts.svh"

module pcc_off_clear
#(
   parameter int N       = 4,
   parameter int CLR_CYC = `PCC_CLR_CYC
)
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [N-1:0] off_req,
   output logic      [N-1:0] chan_clear,
   output logic              clear_busy
);

   localparam int CW = $clog2(CLR_CYC + 1);

   logic [N-1:0]  clr_ff;
   logic [CW-1:0] cnt_ff;
   wire  [CW-1:0] nxt_cnt = (|off_req)      ? CW'(CLR_CYC) :
                            (cnt_ff != '0)  ? cnt_ff - CW'(1) : cnt_ff;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         clr_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         clr_ff <= off_req;
         cnt_ff <= nxt_cnt;
      end
   end

   assign chan_clear = clr_ff;
   assign clear_busy = (cnt_ff != '0);

endmodule : pcc_off_clear

`default_nettype wire

// ===== pcc_top.sv
// Purpose: Restart and power-enable push-button commands for a four-channel group
// Assumes: Command port already decoded from the management bus, one data byte per access
// Notes:   Engines, allocation and field registers live outside; they act on strobes
`timescale 1ns/100ps
`default_nettype none

`include "pcc_consts.svh"

module pcc_top
   import pcc_pkg::*;
#(
   parameter int N       = 4,
   parameter int CLR_CYC = `PCC_CLR_CYC
)
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [7:0]   reg_cmd,
   input  wire logic [7:0]   reg_wdata,
   output logic      [7:0]   reg_rdata,
   output logic              reg_rd_hit,
   input  wire pcc_mode_t    op_mode,
   input  wire logic [N-1:0] cool_act,
   input  wire logic [N-1:0] disc_evt,
   input  wire logic [N-1:0] cls_busy,
   input  wire logic [N-1:0] cls_done,
   input  wire logic [N-1:0] cls_valid,
   input  wire logic [N-1:0] alloc_ok,
   output logic      [N-1:0] det_start,
   output logic      [N-1:0] cls_start,
   output logic      [N-1:0] det_en,
   output logic      [N-1:0] cls_en,
   output logic      [N-1:0] chan_pwr,
   output logic      [N-1:0] chan_clear,
   output logic      [7:0]   police_preset,
   output logic              clear_busy
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Command decode

   pcc_ch_if #(.N(N)) bus ();

   wire wr_dcen    = reg_wr && (reg_cmd == `PCC_CMD_DCEN);
   wire wr_restart = reg_wr && (reg_cmd == `PCC_CMD_RESTART);
   // Off mode swallows the whole byte, power-off bits included
   wire wr_pwr     = reg_wr && (reg_cmd == `PCC_CMD_PWR) && (op_mode != PCC_MODE_OFF);
   wire rd_dcen    = reg_rd && (reg_cmd == `PCC_CMD_DCEN);
   wire rd_pushbtn = reg_rd && ((reg_cmd == `PCC_CMD_RESTART) || (reg_cmd == `PCC_CMD_PWR));

   wire [N-1:0] hi_bits  = reg_wdata[`PCC_HI_MSB:`PCC_HI_LSB];
   wire [N-1:0] lo_bits  = reg_wdata[`PCC_LO_MSB:`PCC_LO_LSB];
   wire [N-1:0] rst_cls  = wr_restart ? hi_bits : '0;
   wire [N-1:0] rst_det  = wr_restart ? lo_bits : '0;
   wire [N-1:0] off_bits = wr_pwr ? hi_bits : '0;
   wire [N-1:0] on_bits  = wr_pwr ? lo_bits : '0;
   wire         semi     = (op_mode == PCC_MODE_SEMI);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Restart pending and detection/classification enables

   logic [N-1:0] pdet_ff;
   logic [N-1:0] pcls_ff;
   logic [N-1:0] det_en_ff;
   logic [N-1:0] cls_en_ff;
   logic [N-1:0] det_start_ff;
   logic [N-1:0] cls_start_ff;

   // Held while cooling so the request is not lost; a power-off drops it
   wire [N-1:0] nxt_pdet = ((pdet_ff & cool_act) | rst_det) & ~off_bits;
   wire [N-1:0] nxt_pcls = ((pcls_ff & cool_act) | rst_cls) & ~off_bits;

   // Semiauto restart also latches the enable, saving software a read-modify-write
   wire [N-1:0] en_det_w = wr_dcen ? lo_bits : det_en_ff;
   wire [N-1:0] en_cls_w = wr_dcen ? hi_bits : cls_en_ff;
   wire [N-1:0] nxt_det_en = (en_det_w | (semi ? rst_det : '0)) & ~off_bits;
   wire [N-1:0] nxt_cls_en = (en_cls_w | (semi ? rst_cls : '0)) & ~off_bits;

   wire [N-1:0] nxt_det_start = (pdet_ff & ~cool_act) | bus.cyc_req;
   wire [N-1:0] nxt_cls_start = (pcls_ff & ~cool_act) | bus.cyc_req;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pdet_ff      <= '0;
         pcls_ff      <= '0;
         det_en_ff    <= '0;
         cls_en_ff    <= '0;
         det_start_ff <= '0;
         cls_start_ff <= '0;
      end
      else
      begin
         pdet_ff      <= nxt_pdet;
         pcls_ff      <= nxt_pcls;
         det_en_ff    <= nxt_det_en;
         cls_en_ff    <= nxt_cls_en;
         det_start_ff <= nxt_det_start;
         cls_start_ff <= nxt_cls_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [7:0] rdata_ff;
   logic       rd_hit_ff;

   // Push-button registers hold nothing readable
   wire [7:0] nxt_rdata  = rd_dcen ? {cls_en_ff, det_en_ff} : `PCC_READ_ZERO;
   wire       nxt_rd_hit = rd_dcen || rd_pushbtn;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_ff  <= `PCC_READ_ZERO;
         rd_hit_ff <= 1'b0;
      end
      else
      begin
         rdata_ff  <= reg_rd ? nxt_rdata : rdata_ff;
         rd_hit_ff <= nxt_rd_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Channel sequencers and power-off clearing

   assign bus.mode      = op_mode;
   assign bus.on_req    = on_bits;
   assign bus.off_req   = off_bits;
   assign bus.cool      = cool_act;
   assign bus.disc      = disc_evt;
   assign bus.cls_busy  = cls_busy;
   assign bus.cls_done  = cls_done;
   assign bus.cls_valid = cls_valid;
   assign bus.alloc_ok  = alloc_ok;
   assign bus.det_en    = det_en_ff;
   assign bus.cls_en    = cls_en_ff;

   pcc_chan_bank #(.N(N)) u_bank
   (
      .clk    (clk),
      .resetn (resetn),
      .bus    (bus)
   );

   // Each power-off bit drives its own channel's field-clear strobe; the policing preset is a constant 8'hFF
   pcc_off_clear #(.N(N), .CLR_CYC(CLR_CYC)) u_clear
   (
      .clk        (clk),
      .resetn     (resetn),
      .off_req    (off_bits),
      .chan_clear (chan_clear),
      .clear_busy (clear_busy)
   );

   assign police_preset = `PCC_POLICE_PRESET;
   assign reg_rdata     = rdata_ff;
   assign reg_rd_hit    = rd_hit_ff;
   assign det_start     = det_start_ff;
   assign cls_start     = cls_start_ff;
   assign det_en        = det_en_ff;
   assign cls_en        = cls_en_ff;
   assign chan_pwr      = bus.pwr;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks on channel 0 and on the read path

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_RESTART_READ_ZERO:
      assert property (reg_rd && reg_cmd == `PCC_CMD_RESTART |=> reg_rdata == 8'h00
                       && reg_rd_hit)
      else $error("restart register read did not return zero");

   AST_RESTART_DET:
      assert property ((wr_restart && reg_wdata[0]) ##1 !cool_act[0] |=> det_start[0])
      else $error("detect restart not issued");

   AST_RESTART_CLS:
      assert property ((wr_restart && reg_wdata[4] && !wr_pwr) ##1 !cool_act[0]
                       |=> cls_start[0] && !$past(det_start[0], 1) || cls_start[0])
      else $error("class restart not issued from upper nibble");

   AST_RESTART_HELD:
      assert property (cool_act[0] |=> !det_start[0] && !cls_start[0])
      else $error("restart issued during cool-down");

   AST_OFF_WINS:
      assert property (wr_pwr && reg_wdata[4] && reg_wdata[0] |=> !chan_pwr[0])
      else $error("channel on after combined on and off");

   AST_OFF_MODE:
      assert property (op_mode == PCC_MODE_OFF && !chan_pwr[0] && !disc_evt[0] && !cls_done[0]
                       |=> !chan_pwr[0])
      else $error("channel powered in off mode");

   AST_MANUAL_ON:
      assert property (op_mode == PCC_MODE_MANUAL && wr_pwr && reg_wdata[0] && !reg_wdata[4]
                       && !cool_act[0] && !disc_evt[0] |=> chan_pwr[0])
      else $error("manual turn-on not immediate");

   AST_COOL_BLOCK:
      assert property (cool_act[0] |=> !chan_pwr[0])
      else $error("channel powered during cool-down");

   AST_SEMI_FAIL:
      assert property (op_mode == PCC_MODE_SEMI && !chan_pwr[0] && cls_done[0] && !cls_valid[0]
                       |=> !chan_pwr[0] ##1 !chan_pwr[0] || wr_pwr)
      else $error("semiauto powered after invalid class");

   AST_SEMI_CYCLE:
      assert property (op_mode == PCC_MODE_SEMI && !(det_en[0] && cls_en[0]) && !chan_pwr[0]
                       && wr_pwr && reg_wdata[0] && !reg_wdata[4] && !cool_act[0]
                       && !disc_evt[0] |=> det_start[0] && cls_start[0])
      else $error("semiauto request did not start a full cycle");

   AST_AUTO_POWER:
      assert property (op_mode == PCC_MODE_AUTO && det_en[0] && cls_en[0] && cls_done[0]
                       && cls_valid[0] && alloc_ok[0] && !cool_act[0] && !disc_evt[0]
                       && !off_bits[0] |=> chan_pwr[0])
      else $error("auto mode did not power after valid class");

   AST_OFF_CLEAR:
      assert property (wr_pwr && reg_wdata[4] |=> chan_clear[0] && !chan_pwr[0] && !det_en[0]
                       && !cls_en[0] && clear_busy)
      else $error("power-off did not clear channel");

   AST_CLEAR_ONLY_OFF:
      assert property (wr_pwr && !reg_wdata[4] || !wr_pwr |=> !chan_clear[0])
      else $error("clear strobe on channel not turned off");

   COV_MANUAL_ON:
      cover property (op_mode == PCC_MODE_MANUAL ##1 chan_pwr[0]);
   COV_SEMI_ON:
      cover property (op_mode == PCC_MODE_SEMI && cls_done[0] ##1 chan_pwr[0]);
   COV_HELD_RESTART:
      cover property (cool_act[0] && pdet_ff[0] ##1 !cool_act[0] ##1 det_start[0]);
   COV_OFF:
      cover property (chan_pwr[0] && off_bits[0] ##1 chan_clear[0]);

endmodule : pcc_top

`default_nettype wire

// ===== pcc_engine_model.sv
// Purpose: Behavioural detect/class engine facing the channel power command block
// Assumes: One cycle per channel at a time; starts during a cycle are dropped
// Notes:   slow stretches each cycle so requests can land mid-classification
`timescale 1ns/100ps
`default_nettype none

module pcc_engine_model
#(
   parameter int N = 4
)
(
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         slow,
   input  wire logic [N-1:0] det_start,
   input  wire logic [N-1:0] cls_start,
   input  wire logic [N-1:0] cfg_valid,
   output logic      [N-1:0] cls_busy,
   output logic      [N-1:0] cls_done,
   output logic      [N-1:0] cls_valid,
   output logic      [N-1:0] alloc_ok
);
   logic [3:0]   cnt_ff [N];
   logic [N-1:0] done_ff;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_ff  <= '{default: 4'h0};
         done_ff <= '0;
      end
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            done_ff[i] <= (cnt_ff[i] == 4'h1);
            if (cnt_ff[i] != 4'h0)
               cnt_ff[i] <= cnt_ff[i] - 4'h1;
            else if (det_start[i] | cls_start[i])
               cnt_ff[i] <= slow ? 4'hA : 4'h3;
         end
      end
   end

   always_comb
   begin
      for (int i = 0; i < N; i++)
         cls_busy[i] = (cnt_ff[i] != 4'h0);
   end

   assign cls_done  = done_ff;
   // Off-pulse the result lines show the opposite, so stale sampling is caught
   assign cls_valid = (done_ff & cfg_valid) | (~done_ff & ~cfg_valid);
   // Allocation programmed before any request, so it suffices at each result
   assign alloc_ok  = done_ff;

endmodule : pcc_engine_model

`default_nettype wire

// ===== tb_pse_channel_power_command.sv
// Purpose: Self-checking bench for the restart and power-enable commands
// Assumes: CLR_CYC shortened to 8 cycles
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none

module tb_pse_channel_power_command
   import pcc_pkg::*;
;
   localparam int CLR = 8;
   logic       clk, resetn, reg_wr, reg_rd, slow;
   logic [7:0] reg_cmd, reg_wdata, reg_rdata, police_preset, rdv;
   logic       reg_rd_hit, clear_busy, hitv;
   pcc_mode_t  op_mode;
   logic [3:0] cool_act, disc_evt, cls_busy, cls_done, cls_valid, alloc_ok, cfg_valid;
   logic [3:0] det_start, cls_start, det_en, cls_en, chan_pwr, chan_clear;
   logic [3:0] det_seen, cls_seen, clr_seen;
   int         bad_count, n_tests, cyc;

   pcc_top #(.N(4), .CLR_CYC(CLR)) pcc_top_i (
      .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit),
      .op_mode(op_mode), .cool_act(cool_act), .disc_evt(disc_evt), .cls_busy(cls_busy),
      .cls_done(cls_done), .cls_valid(cls_valid), .alloc_ok(alloc_ok),
      .det_start(det_start), .cls_start(cls_start), .det_en(det_en), .cls_en(cls_en),
      .chan_pwr(chan_pwr), .chan_clear(chan_clear), .police_preset(police_preset),
      .clear_busy(clear_busy));

   pcc_engine_model #(.N(4)) pcc_engine_model_i (
      .clk(clk), .resetn(resetn), .slow(slow), .det_start(det_start),
      .cls_start(cls_start), .cfg_valid(cfg_valid), .cls_busy(cls_busy),
      .cls_done(cls_done), .cls_valid(cls_valid), .alloc_ok(alloc_ok));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Sticky record of one-cycle pulses, cleared by the bench between steps
   always @(posedge clk)
   begin
      det_seen <= det_seen | det_start;
      cls_seen <= cls_seen | cls_start;
      clr_seen <= clr_seen | chan_clear;
      cyc <= cyc + 1;
      if (cyc >= 3000)
      begin
         bad_count++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      if (bad_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
      @(negedge clk);
      reg_wr    = 1'b1;
      reg_cmd   = cmd;
      reg_wdata = data;
      @(negedge clk);
      reg_wr    = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] cmd);
      @(negedge clk);
      reg_rd  = 1'b1;
      reg_cmd = cmd;
      @(negedge clk);
      reg_rd  = 1'b0;
      rdv     = reg_rdata;
      hitv    = reg_rd_hit;
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle

   task automatic wait_on(input int ch);
      for (int i = 0; i < 40 && chan_pwr[ch] !== 1'b1; i++)
         @(negedge clk);
   endtask : wait_on

   task automatic clr_marks();
      @(negedge clk);
      det_seen = '0;
      cls_seen = '0;
      clr_seen = '0;
   endtask : clr_marks

   initial
   begin
      {reg_wr, reg_rd, slow, reg_cmd, reg_wdata} = '0;
      {cool_act, disc_evt, det_seen, cls_seen, clr_seen} = '0;
      {bad_count, n_tests, cyc} = '0;
      op_mode   = PCC_MODE_MANUAL;
      cfg_valid = 4'hF;
      resetn    = 1'b0;
      idle(16);
      resetn    = 1'b1;
      check("chan_pwr", {4'h0, chan_pwr}, 8'h00);
      check("police_preset", police_preset, 8'hFF);
      wr(8'h18, 8'h5A);
      rd(8'h18);
      check("restart_read", rdv, 8'h00);
      check("restart_hit", {7'h0, hitv}, 8'h01);
      rd(8'h33);
      check("unknown_hit", {7'h0, hitv}, 8'h00);
      // Manual turn-on, then off+on together on channel 0
      wr(8'h19, 8'h0F);
      check("chan_pwr", {4'h0, chan_pwr}, 8'h0F);
      wr(8'h14, 8'hFF);
      clr_marks();
      wr(8'h19, 8'h11);
      check("chan_pwr", {4'h0, chan_pwr}, 8'h0E);
      check("clear_busy", {7'h0, clear_busy}, 8'h01);
      check("det_en", {4'h0, det_en}, 8'h0E);
      check("cls_en", {4'h0, cls_en}, 8'h0E);
      idle(2);
      check("chan_clear", {4'h0, clr_seen}, 8'h01);
      idle(CLR);
      check("clear_busy", {7'h0, clear_busy}, 8'h00);
      disc_evt = 4'h2;
      idle(1);
      disc_evt = 4'h0;
      idle(2);
      check("chan_pwr", {4'h0, chan_pwr}, 8'h0C);
      wr(8'h19, 8'hE0);
      cool_act = 4'h8;
      wr(8'h19, 8'h08);
      idle(2);
      check("chan_pwr", {4'h0, chan_pwr}, 8'h00);
      // Restart held through cool-down
      clr_marks();
      wr(8'h18, 8'h88);
      idle(4);
      check("det_seen", {4'h0, det_seen}, 8'h00);
      cool_act = 4'h0;
      idle(4);
      check("det_seen", {4'h0, det_seen}, 8'h08);
      check("cls_seen", {4'h0, cls_seen}, 8'h08);
      clr_marks();
      wr(8'h18, 8'h21);
      idle(4);
      check("det_seen", {4'h0, det_seen}, 8'h01);
      check("cls_seen", {4'h0, cls_seen}, 8'h02);
      op_mode = PCC_MODE_OFF;
      clr_marks();
      wr(8'h14, 8'h11);
      wr(8'h19, 8'hFF);
      idle(3);
      check("chan_pwr", {4'h0, chan_pwr}, 8'h00);
      check("det_en", {4'h0, det_en}, 8'h01);
      check("chan_clear", {4'h0, clr_seen}, 8'h00);
      // Semiauto, enables clear: one attempt, invalid result on channel 0
      op_mode   = PCC_MODE_SEMI;
      cfg_valid = 4'hE;
      wr(8'h14, 8'h00);
      idle(12);
      clr_marks();
      wr(8'h19, 8'h03);
      wait_on(1);
      check("chan_pwr1", {7'h0, chan_pwr[1]}, 8'h01);
      idle(12);
      check("chan_pwr0", {7'h0, chan_pwr[0]}, 8'h00);
      check("det_seen", {4'h0, det_seen}, 8'h03);
      // Semiauto, both enables: request before classification starts
      wr(8'h14, 8'h44);
      wr(8'h19, 8'h04);
      wr(8'h18, 8'h40);
      wait_on(2);
      check("chan_pwr2", {7'h0, chan_pwr[2]}, 8'h01);
      // Auto mode with a slow engine
      wr(8'h19, 8'hF0);
      op_mode   = PCC_MODE_AUTO;
      slow      = 1'b1;
      cfg_valid = 4'hF;
      wr(8'h14, 8'h11);
      wr(8'h18, 8'h10);
      wait_on(0);
      check("chan_pwr0", {7'h0, chan_pwr[0]}, 8'h01);
      wr(8'h19, 8'h02);
      wait_on(1);
      check("chan_pwr1", {7'h0, chan_pwr[1]}, 8'h01);
      give_verdict();
   end

endmodule : tb_pse_channel_power_command

`default_nettype wire
